// *** common/xpt_ctrl_pkg.sv ***
// Package with constants and types for the crosspoint mode control
// Contract
// RULE_01 - Port select strap not low selects register-based configuration
// RULE_02 - Register select bits: 00 down, 01 USB, 10 four display, 11 both
// RULE_03 - Orientation bit flips lane routing; ignored in power down
// RULE_04 - Select 10 gives four display lanes, no USB path
// RULE_05 - Select 11: USB plus two display lanes, orientation picks pairs
// RULE_06 - No override: AUX by orientation when display on, else open
// RULE_07 - Override 01 straight, 10 crossed, 11 open, regardless of config
// RULE_08 - Display enable from pins in pin mode, else from register bits
// RULE_09 - Separate equalization gain held per receiver lane
// RULE_10 - Pin mode: two four-level pins form gain 0..15, high pin weightier
// RULE_11 - Register mode: seven per-lane gain fields with same 16 choices
// RULE_12 - While USB enabled track Disconnect, U2/U3, U1, U0 from line state
// RULE_13 - Disconnect until termination on both ports, then straight to U0
// RULE_14 - U0 redrives both ports; electrical idle on both moves to U1
// RULE_15 - U1 keeps termination and transmitter common mode on both ports
// RULE_16 - U2/U3 polls far-end detection; missing termination goes Disconnect
// RULE_17 - U2/U3 valid low-frequency burst goes directly to U0
// RULE_18 - U2/U3 keeps terminations but drops transmitter common mode
// RULE_19 - Power-good raised no more than 500 us after supply minimum
// RULE_20 - Straps held stable 250 us before to 10 us after power good
// RULE_21 - Control and orientation pins debounced within 16 ms
// RULE_22 - Pin mode starts in USB; pulse on USB-enable pin clears it
// RULE_23 - From U1 return to U0 when signalling resumes on either port
package xpt_ctrl_pkg;
	localparam int CLK_MHZ = 100;
	localparam int PG_DELAY_US = 500;
	localparam int PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
	localparam int STRAP_HOLD_US = 10;
	localparam int STRAP_HOLD_CYC = STRAP_HOLD_US * CLK_MHZ;
	localparam int DEBOUNCE_MS = 16;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
	localparam int DETECT_PERIOD_US = 100;
	localparam int DETECT_PERIOD_CYC = DETECT_PERIOD_US * CLK_MHZ;
	localparam int NUM_LANES = 7;
	localparam logic [3:0] GAIN_RESET = 4'h0;

	// AHB register byte offsets
	localparam logic [7:0] ADDR_GENERAL = 8'h00;
	localparam logic [7:0] ADDR_GAIN = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam int GEN_SEL_LSB = 0;
	localparam int GEN_ORIENT = 2;
	localparam int GEN_OVR_LSB = 3;
	localparam logic [4:0] GEN_RESET = 5'h01;

	typedef enum logic [1:0] {
		CFG_DOWN = 2'b00,
		CFG_USB = 2'b01,
		CFG_DISP4 = 2'b10,
		CFG_USB_DISP2 = 2'b11
	} cfg_e;

	typedef enum logic [1:0] {
		LINK_DISC = 2'b00,
		LINK_U23 = 2'b01,
		LINK_U1 = 2'b10,
		LINK_U0 = 2'b11
	} link_e;

	typedef enum logic [1:0] {
		AUX_OPEN = 2'b00,
		AUX_STRAIGHT = 2'b01,
		AUX_CROSSED = 2'b10
	} aux_e;

	// Four-level strap: 0, R, F, 1 encoded as 0..3
	typedef struct packed {
		logic [1:0] hi;
		logic [1:0] lo;
	} strap_pair_s;

	typedef struct packed {
		logic usb_path;
		logic disp_lanes4;
		logic disp_lanes2;
		logic flipped;
	} route_s;

	typedef struct packed {
		logic rx_term;
		logic tx_cm;
		logic redrive;
		logic detect_poll;
	} phy_ctl_s;
endpackage

// *** logic/xpt_mode_ctrl.sv ***
// Mode, routing, gain and USB link-state control for the crosspoint switch
`timescale 1ns/100ps
`default_nettype none
module xpt_mode_ctrl
	import xpt_ctrl_pkg::*;
#(
	parameter int PG_CYC = PG_DELAY_CYC,
	parameter int DB_CYC = DEBOUNCE_CYC,
	parameter int POLL_CYC = DETECT_PERIOD_CYC,
	parameter int HOLD_CYC = STRAP_HOLD_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_supply_ok,
	input wire logic i_cfg_port_sel,
	input wire strap_pair_s i_port_gain_pins,
	input wire strap_pair_s i_upstream_gain_pins,
	input wire strap_pair_s i_display_gain_pins,
	input wire logic i_usb_enable_pin,
	input wire logic i_display_enable_pin,
	input wire logic i_orientation_pin,
	input wire logic [1:0] i_far_term,
	input wire logic [1:0] i_elec_idle,
	input wire logic [1:0] i_lfps_valid,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_power_good,
	output logic o_reg_mode,
	output route_s o_route,
	output logic [1:0] o_aux_map,
	output logic [NUM_LANES*4-1:0] o_lane_gain,
	output logic [1:0] o_link_state,
	output phy_ctl_s o_phy_ctl
);
	// Synchronisers for pin-level inputs
	logic [10:0] sync1_ff, sync2_ff;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {i_supply_ok, i_cfg_port_sel, i_usb_enable_pin,
				i_display_enable_pin, i_orientation_pin, i_far_term,
				i_elec_idle, i_lfps_valid};
			sync2_ff <= sync1_ff;
		end
	end
	logic supply_s, portsel_s, usb_pin_s, disp_pin_s, orient_pin_s;
	logic [1:0] term_s, idle_s, lfps_s;
	assign {supply_s, portsel_s, usb_pin_s, disp_pin_s, orient_pin_s,
		term_s, idle_s, lfps_s} = sync2_ff;

	// Strap buses are multi-bit; held stable by controller, so two stages
	logic [11:0] strap1_ff, strap2_ff;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			strap1_ff <= '0;
			strap2_ff <= '0;
		end else begin
			strap1_ff <= {i_port_gain_pins, i_upstream_gain_pins,
				i_display_gain_pins};
			strap2_ff <= strap1_ff;
		end
	end

	// Power good after supply minimum
	logic [31:0] pg_cnt_ff;
	logic power_good_ff;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pg_cnt_ff <= '0;
			power_good_ff <= 1'b0;
		end else if (!supply_s) begin
			pg_cnt_ff <= '0;
			power_good_ff <= 1'b0;
		end else if (pg_cnt_ff < 32'(PG_CYC - 4)) begin // RULE_19
			pg_cnt_ff <= pg_cnt_ff + 32'h1;
		end else begin
			power_good_ff <= 1'b1; // RULE_19
		end
	end

	// Straps caught at power good plus hold time
	logic [31:0] hold_cnt_ff;
	logic latched_ff, reg_mode_ff;
	logic [11:0] strap_lat_ff;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_cnt_ff <= '0;
			latched_ff <= 1'b0;
			reg_mode_ff <= 1'b0;
			strap_lat_ff <= '0;
		end else if (!power_good_ff) begin
			hold_cnt_ff <= '0;
			latched_ff <= 1'b0;
		end else if (!latched_ff) begin
			if (hold_cnt_ff < 32'(HOLD_CYC - 1)) begin // RULE_20
				hold_cnt_ff <= hold_cnt_ff + 32'h1;
			end else begin
				latched_ff <= 1'b1;
				reg_mode_ff <= portsel_s; // RULE_01
				strap_lat_ff <= strap2_ff;
			end
		end
	end

	// Debounce of control and orientation pins
	logic [2:0] db_val_ff;
	logic [31:0] db_cnt_ff [3];
	logic [2:0] pin_vec;
	assign pin_vec = {usb_pin_s, disp_pin_s, orient_pin_s};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_db
			always_ff @(posedge i_core_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					db_cnt_ff[g] <= '0;
					db_val_ff[g] <= (g == 0) ? 1'b1 : 1'b0;
				end else if (pin_vec[g] == db_val_ff[g]) begin
					db_cnt_ff[g] <= '0;
				end else if (db_cnt_ff[g] < 32'(DB_CYC - 4)) begin // RULE_21
					db_cnt_ff[g] <= db_cnt_ff[g] + 32'h1;
				end else begin
					db_cnt_ff[g] <= '0;
					db_val_ff[g] <= pin_vec[g]; // RULE_21
				end
			end
		end
	endgenerate
	logic usb_db, disp_db, orient_db;
	assign {usb_db, disp_db, orient_db} = db_val_ff;

	// USB default on in pin mode until the enable pin pulses high then low
	logic usb_default_ff, usb_pin_seen_hi_ff;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			usb_default_ff <= 1'b1;
			usb_pin_seen_hi_ff <= 1'b0;
		end else if (usb_db) begin
			usb_pin_seen_hi_ff <= 1'b1;
		end else if (usb_pin_seen_hi_ff) begin
			usb_default_ff <= 1'b0; // RULE_22
		end
	end

	// AHB-Lite slave: zero wait state, always OKAY
	logic [4:0] gen_ff;
	logic [27:0] gain_reg_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic [1:0] link_ff;
	logic addr_phase;
	assign addr_phase = i_hsel & i_htrans[1] & i_hready;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
		end else begin
			wr_pend_ff <= addr_phase & i_hwrite;
			wr_addr_ff <= i_haddr[7:0];
		end
	end
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			gen_ff <= GEN_RESET;
			gain_reg_ff <= '0;
		end else if (wr_pend_ff) begin
			if (wr_addr_ff == ADDR_GENERAL)
				gen_ff <= i_hwdata[4:0];
			if (wr_addr_ff == ADDR_GAIN)
				gain_reg_ff <= i_hwdata[27:0]; // RULE_11
		end
	end
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hrdata_ff <= '0;
		end else if (addr_phase && !i_hwrite) begin
			unique case (i_haddr[7:0])
				ADDR_GENERAL: hrdata_ff <= {27'h0, gen_ff};
				ADDR_GAIN: hrdata_ff <= {4'h0, gain_reg_ff};
				ADDR_STATUS: hrdata_ff <= {27'h0, reg_mode_ff,
					latched_ff, power_good_ff, link_ff};
				default: hrdata_ff <= '0;
			endcase
		end
	end
	assign o_hrdata = hrdata_ff;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	// Effective configuration
	cfg_e cfg;
	logic orient;
	always_comb begin
		if (reg_mode_ff) begin
			cfg = cfg_e'(gen_ff[GEN_SEL_LSB +: 2]); // RULE_02
			orient = gen_ff[GEN_ORIENT];
		end else begin
			cfg = cfg_e'({disp_db, usb_db | usb_default_ff}); // RULE_08
			orient = orient_db;
		end
		if (!latched_ff)
			cfg = CFG_DOWN;
	end

	// Routing and sideband
	route_s route_ff;
	logic [1:0] aux_ff;
	logic [1:0] ovr;
	assign ovr = reg_mode_ff ? gen_ff[GEN_OVR_LSB +: 2] : 2'b00;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			route_ff <= '0;
			aux_ff <= AUX_OPEN;
		end else begin
			route_ff.usb_path <= cfg[0]; // RULE_04
			route_ff.disp_lanes4 <= (cfg == CFG_DISP4); // RULE_04
			route_ff.disp_lanes2 <= (cfg == CFG_USB_DISP2); // RULE_05
			route_ff.flipped <= (cfg != CFG_DOWN) & orient; // RULE_03
			unique case (ovr)
				2'b01: aux_ff <= AUX_STRAIGHT; // RULE_07
				2'b10: aux_ff <= AUX_CROSSED; // RULE_07
				2'b11: aux_ff <= AUX_OPEN; // RULE_07
				2'b00: aux_ff <= !cfg[1] ? AUX_OPEN :
					(orient ? AUX_CROSSED : AUX_STRAIGHT); // RULE_06
			endcase
		end
	end

	// Per-lane gain: display0..3, usb1, usb2, upstream
	logic [3:0] gain_ff [NUM_LANES];
	logic [3:0] pin_gain [NUM_LANES];
	strap_pair_s sp_port, sp_up, sp_disp;
	assign {sp_port, sp_up, sp_disp} = strap_lat_ff;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : g_gain
			assign pin_gain[g] = (g < 4) ? {sp_disp.hi, sp_disp.lo} :
				(g < 6) ? {sp_port.hi, sp_port.lo} :
				{sp_up.hi, sp_up.lo}; // RULE_10
			always_ff @(posedge i_core_clk or negedge i_reset_n) begin
				if (!i_reset_n)
					gain_ff[g] <= GAIN_RESET;
				else
					gain_ff[g] <= reg_mode_ff ? gain_reg_ff[g*4 +: 4] :
						pin_gain[g]; // RULE_09
			end
			assign o_lane_gain[g*4 +: 4] = gain_ff[g];
		end
	endgenerate

	// USB link state
	link_e link_st;
	logic [31:0] poll_cnt_ff;
	logic poll_ff;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			poll_cnt_ff <= '0;
			poll_ff <= 1'b0;
		end else if (link_st != LINK_U23 ||
			poll_cnt_ff >= 32'(POLL_CYC - 1)) begin
			poll_cnt_ff <= '0;
			poll_ff <= (link_st == LINK_U23); // RULE_16
		end else begin
			poll_cnt_ff <= poll_cnt_ff + 32'h1;
			poll_ff <= 1'b0;
		end
	end
	assign link_st = link_e'(link_ff);
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			link_ff <= LINK_DISC;
		end else if (!cfg[0]) begin
			link_ff <= LINK_DISC; // RULE_12
		end else begin
			unique case (link_st)
				LINK_DISC: if (&term_s) link_ff <= LINK_U0; // RULE_13
				LINK_U0: if (&idle_s) link_ff <= LINK_U1; // RULE_14
				LINK_U1: if (~&idle_s) link_ff <= LINK_U0; // RULE_23
					else if (~&term_s) link_ff <= LINK_U23;
				LINK_U23: if (poll_ff && ~&term_s)
						link_ff <= LINK_DISC; // RULE_16
					else if (|lfps_s) link_ff <= LINK_U0; // RULE_17
			endcase
		end
	end

	phy_ctl_s phy_ff;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phy_ff <= '0;
		end else begin
			phy_ff.rx_term <= cfg[0] && link_st != LINK_DISC; // RULE_15
			phy_ff.tx_cm <= cfg[0] && (link_st == LINK_U0 ||
				link_st == LINK_U1); // RULE_18
			phy_ff.redrive <= cfg[0] && link_st == LINK_U0; // RULE_14
			phy_ff.detect_poll <= poll_ff;
		end
	end

	assign o_power_good = power_good_ff;
	assign o_reg_mode = reg_mode_ff;
	assign o_route = route_ff;
	assign o_aux_map = aux_ff;
	assign o_link_state = link_ff;
	assign o_phy_ctl = phy_ff;

	property p_disc_to_u0;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(link_st == LINK_DISC && cfg[0] && &term_s) |=> link_st == LINK_U0;
	endproperty
	a_disc_to_u0: assert property (p_disc_to_u0) // RULE_13
		else $error("no U0 entry");
	property p_u0_to_u1;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(link_st == LINK_U0 && cfg[0] && &idle_s) |=> link_st == LINK_U1;
	endproperty
	a_u0_to_u1: assert property (p_u0_to_u1) // RULE_14
		else $error("no U1 entry");
	property p_u23_lfps;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(link_st == LINK_U23 && cfg[0] && !poll_ff && |lfps_s)
			|=> link_st == LINK_U0;
	endproperty
	a_u23_lfps: assert property (p_u23_lfps) // RULE_17
		else $error("no LFPS wake");
	property p_u23_cm;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(link_st == LINK_U23 && cfg[0]) |=> !phy_ff.tx_cm && phy_ff.rx_term;
	endproperty
	a_u23_cm: assert property (p_u23_cm) // RULE_18
		else $error("U2/U3 phy wrong");
	property p_u1_cm;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(link_st == LINK_U1 && cfg[0]) |=> phy_ff.tx_cm && phy_ff.rx_term;
	endproperty
	a_u1_cm: assert property (p_u1_cm) // RULE_15
		else $error("U1 phy wrong");
	property p_ovr_straight;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(ovr == 2'b01) |=> aux_ff == AUX_STRAIGHT;
	endproperty
	a_ovr_straight: assert property (p_ovr_straight) // RULE_07
		else $error("aux ovr");
	property p_disp4;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(cfg == CFG_DISP4) |=> route_ff.disp_lanes4 && !route_ff.usb_path;
	endproperty
	a_disp4: assert property (p_disp4) // RULE_04
		else $error("disp4 route");
	property p_down_flip;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(cfg == CFG_DOWN) |=> !route_ff.flipped;
	endproperty
	a_down_flip: assert property (p_down_flip) // RULE_03
		else $error("flip in down");
	sequence s_u23_term_lost;
		link_st == LINK_U23 && cfg[0] && poll_ff && ~&term_s;
	endsequence
	property p_u23_disc;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		s_u23_term_lost |=> link_st == LINK_DISC;
	endproperty
	a_u23_disc: assert property (p_u23_disc) // RULE_16
		else $error("no disconnect");
endmodule
`default_nettype wire

// *** tb/pd_ctrl_model.sv ***
// Controller-side model that drives the straps and the control pins
`timescale 1ns/100ps
`default_nettype none
module pd_ctrl_model
	import xpt_ctrl_pkg::*;
(
	input wire logic i_core_clk,
	output logic o_cfg_port_sel,
	output strap_pair_s o_port_gain,
	output strap_pair_s o_upstream_gain,
	output strap_pair_s o_display_gain,
	output logic o_usb_pin,
	output logic o_display_pin,
	output logic o_orient_pin
);
	initial begin
		o_cfg_port_sel = 1'b1;
		o_port_gain = '0;
		o_upstream_gain = '0;
		o_display_gain = '0;
		o_usb_pin = 1'b0;
		o_display_pin = 1'b0;
		o_orient_pin = 1'b0;
	end

	// Only called while the device sits in reset, so straps hold long
	// before power good and well past the latch point
	task automatic set_straps(input logic sel, input strap_pair_s p, u, d);
		@(posedge i_core_clk);
		o_cfg_port_sel <= sel;
		o_port_gain <= p;
		o_upstream_gain <= u;
		o_display_gain <= d;
	endtask

	task automatic set_ctl(input logic usb, disp, orient);
		@(posedge i_core_clk);
		o_usb_pin <= usb;
		o_display_pin <= disp;
		o_orient_pin <= orient;
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the crosspoint mode control
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
	n_errors++; $display("unexpected %s exp %0h got %0h", nm, exp, got); end end
module testbench
	import xpt_ctrl_pkg::*;
;
	localparam int PG = 40;
	localparam int DB = 20;
	localparam int POLL = 200;
	logic clk, rst_n, supply_ok, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, far_term, elec_idle, lfps, aux, link;
	logic [2:0] hsize;
	logic cfg_sel, usb_pin, disp_pin, orient_pin, pg, reg_mode;
	strap_pair_s port_p, up_p, disp_p;
	route_s route;
	phy_ctl_s phy;
	logic [27:0] gain;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	assign hready = hreadyout;

	pd_ctrl_model partner_u (.i_core_clk(clk), .o_cfg_port_sel(cfg_sel),
		.o_port_gain(port_p), .o_upstream_gain(up_p),
		.o_display_gain(disp_p), .o_usb_pin(usb_pin),
		.o_display_pin(disp_pin), .o_orient_pin(orient_pin));

	xpt_mode_ctrl #(.PG_CYC(PG), .DB_CYC(DB), .POLL_CYC(POLL),
		.HOLD_CYC(5)) dut_u (.i_core_clk(clk), .i_reset_n(rst_n),
		.i_supply_ok(supply_ok), .i_cfg_port_sel(cfg_sel),
		.i_port_gain_pins(port_p), .i_upstream_gain_pins(up_p),
		.i_display_gain_pins(disp_p), .i_usb_enable_pin(usb_pin),
		.i_display_enable_pin(disp_pin), .i_orientation_pin(orient_pin),
		.i_far_term(far_term), .i_elec_idle(elec_idle),
		.i_lfps_valid(lfps), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.o_power_good(pg), .o_reg_mode(reg_mode), .o_route(route),
		.o_aux_map(aux), .o_lane_gain(gain), .o_link_state(link),
		.o_phy_ctl(phy));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic results();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Plenty for the whole run; a hang here means a lost handshake
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic reg_wr(input logic [31:0] a, d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
		cyc(4);
	endtask

	task automatic line(input logic [1:0] t, i, l, input int n);
		far_term <= t;
		elec_idle <= i;
		lfps <= l;
		cyc(n);
	endtask

	task automatic t_power_up(input logic sel);
		supply_ok <= 1'b1;
		for (int i = 0; i < PG && pg !== 1'b1; i++)
			@(posedge clk);
		`CHK("power_good", 1'b1, pg)
		cyc(12);
		`CHK("reg_mode", sel, reg_mode)
	endtask

	task automatic t_config();
		logic [31:0] rd;
		logic [1:0] s;
		logic f;
		route_s e;
		logic [1:0] ea;
		ahb(1'b0, 32'(ADDR_GENERAL), 32'h0, rd);
		`CHK("general_reset", 32'(GEN_RESET), rd)
		for (int i = 0; i < 8; i++) begin
			s = i[2:1];
			f = i[0];
			reg_wr(32'(ADDR_GENERAL), {29'h0, f, s});
			e = {s[0], s == 2'b10, s == 2'b11, f & (s != 2'b00)};
			ea = s[1] ? (f ? AUX_CROSSED : AUX_STRAIGHT) : AUX_OPEN;
			`CHK("route", e, route)
			`CHK("aux_map", ea, aux)
		end
		// Override must beat an enabled, flipped display setting
		for (int o = 1; o < 4; o++) begin
			reg_wr(32'(ADDR_GENERAL), 32'(o << GEN_OVR_LSB) | 32'h6);
			ea = (o == 1) ? AUX_STRAIGHT : (o == 2) ? AUX_CROSSED : AUX_OPEN;
			`CHK("aux_override", ea, aux)
		end
	endtask

	task automatic t_gain_regs();
		logic [31:0] rd;
		reg_wr(32'(ADDR_GAIN), 32'h0f17_5c3e);
		`CHK("lane_gain", 28'hf17_5c3e, gain)
		ahb(1'b0, 32'(ADDR_GAIN), 32'h0, rd);
		`CHK("gain_read", 32'h0f17_5c3e, rd)
		reg_wr(32'h0000_000c, 32'hffff_ffff);
		ahb(1'b0, 32'h0000_000c, 32'h0, rd);
		`CHK("unmapped", 32'h0, rd)
	endtask

	task automatic t_link();
		logic [31:0] rd;
		int np = 0;
		reg_wr(32'(ADDR_GENERAL), 32'h1);
		line(2'b00, 2'b00, 2'b00, 6);
		`CHK("link_disc", LINK_DISC, link)
		line(2'b11, 2'b00, 2'b00, 6);
		`CHK("link_u0", LINK_U0, link)
		`CHK("redrive", 1'b1, phy.redrive)
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0, rd);
		`CHK("status", {27'h0, 3'b111, LINK_U0}, rd)
		line(2'b11, 2'b11, 2'b00, 6);
		`CHK("link_u1", LINK_U1, link)
		`CHK("u1_phy", 2'b11, {phy.rx_term, phy.tx_cm})
		line(2'b11, 2'b01, 2'b00, 6);
		`CHK("u1_exit", LINK_U0, link)
		line(2'b11, 2'b11, 2'b00, 6);
		line(2'b01, 2'b11, 2'b00, 5);
		line(2'b11, 2'b11, 2'b00, 4);
		`CHK("link_u23", LINK_U23, link)
		`CHK("u23_phy", 2'b10, {phy.rx_term, phy.tx_cm})
		line(2'b11, 2'b00, 2'b01, 6);
		`CHK("lfps_wake", LINK_U0, link)
		line(2'b11, 2'b11, 2'b00, 6);
		line(2'b10, 2'b11, 2'b00, 0);
		// One detection pulse ends U2/U3 with a port unterminated
		for (int i = 0; i < POLL + 20; i++) begin
			@(posedge clk);
			if (phy.detect_poll === 1'b1)
				np++;
		end
		`CHK("detect_poll", 1, np)
		`CHK("term_lost", LINK_DISC, link)
	endtask

	task automatic t_pin_mode();
		rst_n <= 1'b0;
		supply_ok <= 1'b0;
		partner_u.set_straps(1'b0, {2'd2, 2'd1}, {2'd3, 2'd0}, {2'd0, 2'd3});
		partner_u.set_ctl(1'b0, 1'b0, 1'b0);
		cyc(5);
		rst_n <= 1'b1;
		t_power_up(1'b0);
		`CHK("pin_gain", {4'd12, 4'd9, 4'd9, {4{4'd3}}}, gain)
		`CHK("usb_default", 1'b1, route.usb_path)
		partner_u.set_ctl(1'b1, 1'b0, 1'b0);
		cyc(DB + 10);
		partner_u.set_ctl(1'b0, 1'b0, 1'b0);
		cyc(DB + 10);
		`CHK("usb_cleared", 1'b0, route.usb_path)
		partner_u.set_ctl(1'b0, 1'b1, 1'b0);
		cyc(DB + 10);
		`CHK("pin_disp4", 1'b1, route.disp_lanes4)
		`CHK("pin_aux", AUX_STRAIGHT, aux)
	endtask

	initial begin
		rst_n = 1'b0;
		supply_ok = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		{far_term, elec_idle, lfps} = '0;
		cyc(20);
		rst_n <= 1'b1;
		t_power_up(1'b1);
		t_config();
		t_gain_regs();
		t_link();
		t_pin_mode();
		results();
	end
endmodule
`default_nettype wire
